// >>> power_energy_pkg.sv
package power_energy_pkg;

  // ****************************************************************
  // Datapath widths
  // ****************************************************************
  localparam int SAMPLE_W = 17;
  localparam int RESULT_W = 16;
  localparam int POWER_MSBS = 14;
  localparam int PRODUCT_W = 31;
  localparam int POWER_W = 28;
  localparam int POWER_SHIFT = PRODUCT_W - POWER_W;
  localparam int ACCUM_W = 48;
  localparam int COUNT_W = 24;
  localparam int PERM_W = 2;

  // ****************************************************************
  // Rolling average
  // ****************************************************************
  localparam int AVG_DEPTH = 8;
  localparam int AVG_IDX_W = 3;
  localparam int AVG_SUM_W = SAMPLE_W + AVG_IDX_W;
  localparam logic [3:0] AVG_WARMUP_CYCLES = 4'h8;

  // ****************************************************************
  // Sign format register
  // ****************************************************************
  localparam logic [7:0] SIGN_FORMAT_ADDR = 8'h1d;
  localparam logic [7:0] SIGN_FORMAT_RESET = 8'h00;
  localparam int SENSE_SIGNED_BIT = 0;
  localparam int BUS_SIGNED_BIT = 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 25;
  localparam int CC_ALERT_TIME_US = 5;
  localparam int CC_ALERT_CYCLES = CC_ALERT_TIME_US * CLK_FREQ_MHZ;
  localparam int CC_CNT_W = 8;

endpackage : power_energy_pkg

// >>> power_energy_accumulator.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Keep eight-sample rolling means per channel
// - Recompute averages on every completed conversion
// - Readable results change only on refresh
// - Averages valid only after eight cycles
// - Step four offset permutations per conversion
// - Carry conversions internally as 17-bit signed
// - Host-set register picks signed/unsigned presentation
// - Unsigned mode exports low sixteen bits
// - Signed bus voltage truncates to 16 bits
// - Signed sense truncates; power keeps 17 bits
// - Power is sense times bus top fourteen
// - Power math always two's complement
// - Sum 28-bit power into 48-bit accumulator
// - 24-bit counter counts accumulated samples
// - Counter overflow wraps, never resets itself
// - Accumulators saturate instead of wrapping
// - Energy signed if either quantity signed
// - Overflow sets flag and enabled alert
// - Plain or general refresh clears overflow
// - Cycle-done alert drives low 5 us
module power_energy_accumulator #(
  parameter int CH_COUNT = 4,
  parameter int CH_IDX_W = 2
) (
  input wire logic clk_sys, // System clock, 25 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic sample_valid, // One conversion result is present.
  input wire logic [CH_IDX_W-1:0] sample_channel, // Channel of the result.
  input wire logic signed [16:0] sample_bus_voltage, // Bus voltage, signed.
  input wire logic signed [16:0] sample_sense_voltage, // Sense voltage, signed.
  input wire logic cycle_done, // Conversion cycle over all channels done.
  input wire logic refresh_plain, // Plain refresh command pulse.
  input wire logic refresh_voltage, // Voltage-only refresh command pulse.
  input wire logic refresh_general, // General-call refresh command pulse.
  input wire logic cfg_wr_en, // Register write strobe.
  input wire logic [7:0] cfg_addr, // Register address.
  input wire logic [7:0] cfg_wdata, // Register write data.
  input wire logic cycle_done_alert_enable, // Alert on cycle completion.
  input wire logic overflow_alert_enable, // Alert on overflow.
  input wire logic alert_in, // Alert pin level, not used internally.
  output logic [7:0] cfg_rdata, // Register read data.
  output logic [CH_COUNT*16-1:0] bus_voltage_result, // Snapshot bus voltage.
  output logic [CH_COUNT*16-1:0] sense_voltage_result, // Snapshot sense voltage.
  output logic [CH_COUNT*16-1:0] avg_bus_voltage_result, // Snapshot bus mean.
  output logic [CH_COUNT*16-1:0] avg_sense_voltage_result, // Snapshot sense mean.
  output logic [CH_COUNT*48-1:0] power_accumulator, // Snapshot accumulators.
  output logic [23:0] accumulator_count, // Snapshot sample count.
  output logic energy_signed, // Snapshot energy is signed.
  output logic overflow_flag, // Sticky overflow status.
  output logic avg_valid, // Averages have settled.
  output logic [CH_COUNT*2-1:0] permute_setting, // Offset permutation per channel.
  output logic alert_out, // Alert pin drive value, always low.
  output logic alert_oe_n // Alert pin enable, low while pulling low.
);

  // ****************************************************************
  // Sign format register and refresh decode
  // ****************************************************************
  logic [7:0] sign_fmt_r, sign_fmt_nxt;
  logic [7:0] cfg_rdata_r, cfg_rdata_nxt;
  logic bus_signed, sense_signed;
  logic refresh_any, ovf_clear;

  assign bus_signed = sign_fmt_r[power_energy_pkg::BUS_SIGNED_BIT];
  assign sense_signed = sign_fmt_r[power_energy_pkg::SENSE_SIGNED_BIT];
  assign refresh_any = refresh_plain | refresh_voltage | refresh_general;
  assign ovf_clear = refresh_plain | refresh_general;

  always_comb begin
    sign_fmt_nxt = sign_fmt_r;
    if (cfg_wr_en && cfg_addr == power_energy_pkg::SIGN_FORMAT_ADDR) begin
      sign_fmt_nxt = cfg_wdata;
    end
    cfg_rdata_nxt = (cfg_addr == power_energy_pkg::SIGN_FORMAT_ADDR) ? sign_fmt_r : 8'h00;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sign_fmt_r <= power_energy_pkg::SIGN_FORMAT_RESET;
      cfg_rdata_r <= 8'h00;
    end else begin
      sign_fmt_r <= sign_fmt_nxt;
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  assign cfg_rdata = cfg_rdata_r;

  // Unsigned presentation keeps the low sixteen bits; signed drops the extra LSB.
  function automatic logic [15:0] present(input logic [16:0] v, input logic signed_sel);
    present = signed_sel ? v[16:1] : v[15:0];
  endfunction : present

  // ****************************************************************
  // Per-channel averaging, permutation and accumulation
  // ****************************************************************
  logic [CH_COUNT-1:0] chan_ovf;

  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : gen_ch
    logic hit;
    logic signed [16:0] bus_hist [power_energy_pkg::AVG_DEPTH];
    logic signed [16:0] sense_hist [power_energy_pkg::AVG_DEPTH];
    logic [2:0] wr_idx_r, wr_idx_nxt;
    logic signed [19:0] bus_sum_r, bus_sum_nxt, sense_sum_r, sense_sum_nxt;
    logic signed [16:0] bus_inst_r, bus_inst_nxt, sense_inst_r, sense_inst_nxt;
    logic signed [47:0] accum_r, accum_nxt;
    logic [1:0] perm_r, perm_nxt;
    logic signed [30:0] product;
    logic signed [13:0] bus_msbs;
    logic signed [27:0] power;
    logic signed [48:0] acc_sum;
    logic ovf;
    logic [15:0] snap_bus_r, snap_bus_nxt, snap_sense_r, snap_sense_nxt;
    logic [15:0] snap_abus_r, snap_abus_nxt, snap_asense_r, snap_asense_nxt;
    logic [47:0] snap_acc_r, snap_acc_nxt;

    assign hit = sample_valid && sample_channel == CH_IDX_W'(ch);
    assign bus_msbs = sample_bus_voltage[16:3];
    assign product = sample_sense_voltage * bus_msbs;
    assign power = product[30:power_energy_pkg::POWER_SHIFT];
    assign acc_sum = {accum_r[47], accum_r} + {{21{power[27]}}, power};
    assign ovf = hit && (acc_sum[48] != acc_sum[47]);
    assign chan_ovf[ch] = ovf;

    always_comb begin
      wr_idx_nxt = wr_idx_r;
      bus_sum_nxt = bus_sum_r;
      sense_sum_nxt = sense_sum_r;
      bus_inst_nxt = bus_inst_r;
      sense_inst_nxt = sense_inst_r;
      accum_nxt = accum_r;
      perm_nxt = perm_r;
      if (hit) begin
        // Running sum drops the oldest entry as the newest arrives.
        bus_sum_nxt = bus_sum_r + 20'(sample_bus_voltage) - 20'(bus_hist[wr_idx_r]);
        sense_sum_nxt = sense_sum_r + 20'(sample_sense_voltage)
                        - 20'(sense_hist[wr_idx_r]);
        wr_idx_nxt = wr_idx_r + 3'h1;
        bus_inst_nxt = sample_bus_voltage;
        sense_inst_nxt = sample_sense_voltage;
        perm_nxt = perm_r + 2'h1;
        if (ovf) begin
          accum_nxt = acc_sum[48] ? {1'b1, 47'h0} : {1'b0, {47{1'b1}}};
        end else begin
          accum_nxt = acc_sum[47:0];
        end
      end
      snap_bus_nxt = snap_bus_r;
      snap_sense_nxt = snap_sense_r;
      snap_abus_nxt = snap_abus_r;
      snap_asense_nxt = snap_asense_r;
      snap_acc_nxt = snap_acc_r;
      if (refresh_any) begin
        snap_bus_nxt = present(bus_inst_r, bus_signed);
        snap_sense_nxt = present(sense_inst_r, sense_signed);
        snap_abus_nxt = present(bus_sum_r[19:3], bus_signed);
        snap_asense_nxt = present(sense_sum_r[19:3], sense_signed);
        snap_acc_nxt = accum_r;
      end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        for (int i = 0; i < power_energy_pkg::AVG_DEPTH; i++) begin
          bus_hist[i] <= 17'h0;
          sense_hist[i] <= 17'h0;
        end
        wr_idx_r <= 3'h0;
        bus_sum_r <= 20'h0;
        sense_sum_r <= 20'h0;
        bus_inst_r <= 17'h0;
        sense_inst_r <= 17'h0;
        accum_r <= 48'h0;
        perm_r <= 2'h0;
        snap_bus_r <= 16'h0;
        snap_sense_r <= 16'h0;
        snap_abus_r <= 16'h0;
        snap_asense_r <= 16'h0;
        snap_acc_r <= 48'h0;
      end else begin
        if (hit) begin
          bus_hist[wr_idx_r] <= sample_bus_voltage;
          sense_hist[wr_idx_r] <= sample_sense_voltage;
        end
        wr_idx_r <= wr_idx_nxt;
        bus_sum_r <= bus_sum_nxt;
        sense_sum_r <= sense_sum_nxt;
        bus_inst_r <= bus_inst_nxt;
        sense_inst_r <= sense_inst_nxt;
        accum_r <= accum_nxt;
        perm_r <= perm_nxt;
        snap_bus_r <= snap_bus_nxt;
        snap_sense_r <= snap_sense_nxt;
        snap_abus_r <= snap_abus_nxt;
        snap_asense_r <= snap_asense_nxt;
        snap_acc_r <= snap_acc_nxt;
      end
    end

    assign bus_voltage_result[ch*16 +: 16] = snap_bus_r;
    assign sense_voltage_result[ch*16 +: 16] = snap_sense_r;
    assign avg_bus_voltage_result[ch*16 +: 16] = snap_abus_r;
    assign avg_sense_voltage_result[ch*16 +: 16] = snap_asense_r;
    assign power_accumulator[ch*48 +: 48] = snap_acc_r;
    assign permute_setting[ch*2 +: 2] = perm_r;
  end

  // ****************************************************************
  // Sample counter, overflow, warm-up and alert
  // ****************************************************************
  logic [23:0] count_r, count_nxt, snap_count_r, snap_count_nxt;
  logic snap_esigned_r, snap_esigned_nxt;
  logic count_ovf, ovf_event;
  logic ovf_flag_r, ovf_flag_nxt, ovf_alert_r, ovf_alert_nxt;
  logic [3:0] warm_r, warm_nxt;
  logic avg_valid_r, avg_valid_nxt;
  logic [7:0] cc_cnt_r, cc_cnt_nxt;
  logic alert_oe_n_r, alert_oe_n_nxt, alert_out_r;

  assign count_ovf = cycle_done && (&count_r);
  assign ovf_event = (|chan_ovf) | count_ovf;

  always_comb begin
    count_nxt = cycle_done ? count_r + 24'h1 : count_r;
    snap_count_nxt = refresh_any ? count_r : snap_count_r;
    snap_esigned_nxt = refresh_any ? (bus_signed | sense_signed) : snap_esigned_r;
    // A new overflow in the clearing cycle keeps the flag set.
    ovf_flag_nxt = ovf_event | (ovf_flag_r & ~ovf_clear);
    ovf_alert_nxt = (ovf_event & overflow_alert_enable) | (ovf_alert_r & ~ovf_clear);
    warm_nxt = warm_r;
    if (cycle_done && warm_r != power_energy_pkg::AVG_WARMUP_CYCLES) begin
      warm_nxt = warm_r + 4'h1;
    end
    avg_valid_nxt = (warm_nxt == power_energy_pkg::AVG_WARMUP_CYCLES);
    if (cycle_done && cycle_done_alert_enable) begin
      cc_cnt_nxt = 8'(power_energy_pkg::CC_ALERT_CYCLES);
    end else if (cc_cnt_r != 8'h0) begin
      cc_cnt_nxt = cc_cnt_r - 8'h1;
    end else begin
      cc_cnt_nxt = cc_cnt_r;
    end
    alert_oe_n_nxt = !(ovf_alert_nxt || cc_cnt_nxt != 8'h0);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_r <= 24'h0;
      snap_count_r <= 24'h0;
      snap_esigned_r <= 1'b0;
      ovf_flag_r <= 1'b0;
      ovf_alert_r <= 1'b0;
      warm_r <= 4'h0;
      avg_valid_r <= 1'b0;
      cc_cnt_r <= 8'h0;
      alert_oe_n_r <= 1'b1;
      alert_out_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      snap_count_r <= snap_count_nxt;
      snap_esigned_r <= snap_esigned_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      ovf_alert_r <= ovf_alert_nxt;
      warm_r <= warm_nxt;
      avg_valid_r <= avg_valid_nxt;
      cc_cnt_r <= cc_cnt_nxt;
      alert_oe_n_r <= alert_oe_n_nxt;
      alert_out_r <= 1'b0;
    end
  end

  assign accumulator_count = snap_count_r;
  assign energy_signed = snap_esigned_r;
  assign overflow_flag = ovf_flag_r;
  assign avg_valid = avg_valid_r;
  assign alert_out = alert_out_r;
  assign alert_oe_n = alert_oe_n_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_snap_hold;
    @(posedge clk_sys) disable iff (reset)
    !refresh_any |=> $stable(avg_bus_voltage_result) && $stable(power_accumulator);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("result moved without refresh");

  property p_snap_copy;
    @(posedge clk_sys) disable iff (reset)
    refresh_any |=> power_accumulator[47:0] == $past(gen_ch[0].accum_r)
                    && accumulator_count == $past(count_r);
  endproperty
  a_snap_copy: assert property (p_snap_copy) else $error("refresh snapshot mismatch");

  property p_ovf_set;
    @(posedge clk_sys) disable iff (reset)
    ovf_event |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow did not set flag");

  property p_ovf_keep;
    @(posedge clk_sys) disable iff (reset)
    overflow_flag && !refresh_plain && !refresh_general |=> overflow_flag;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");

  property p_ovf_clear;
    @(posedge clk_sys) disable iff (reset)
    (refresh_plain || refresh_general) && !ovf_event |=> !overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_cc_alert;
    @(posedge clk_sys) disable iff (reset)
    cycle_done && cycle_done_alert_enable |=> (!alert_oe_n)[*8] ##117 !alert_oe_n;
  endproperty
  a_cc_alert: assert property (p_cc_alert) else $error("cycle alert too short");

  property p_cc_release;
    @(posedge clk_sys) disable iff (reset)
    cc_cnt_r == 8'h1 && !ovf_alert_nxt && !(cycle_done && cycle_done_alert_enable)
    |=> alert_oe_n;
  endproperty
  a_cc_release: assert property (p_cc_release) else $error("cycle alert too long");

  property p_count_wrap;
    @(posedge clk_sys) disable iff (reset)
    cycle_done && (&count_r) |=> count_r == 24'h0 && overflow_flag;
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("counter wrap wrong");

  property p_perm_step;
    @(posedge clk_sys) disable iff (reset)
    sample_valid && sample_channel == CH_IDX_W'(0)
    |=> gen_ch[0].perm_r == 2'($past(gen_ch[0].perm_r) + 2'h1);
  endproperty
  a_perm_step: assert property (p_perm_step) else $error("permutation did not step");

  property p_warmup;
    @(posedge clk_sys) disable iff (reset)
    warm_r < 4'h7 |=> !avg_valid;
  endproperty
  a_warmup: assert property (p_warmup) else $error("averages valid too early");

  property p_saturate;
    @(posedge clk_sys) disable iff (reset)
    gen_ch[0].accum_r == {1'b0, {47{1'b1}}} && !gen_ch[0].power[27]
    |=> gen_ch[0].accum_r == {1'b0, {47{1'b1}}};
  endproperty
  a_saturate: assert property (p_saturate) else $error("accumulator wrapped");

endmodule : power_energy_accumulator

`default_nettype wire

// >>> host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host controller model
// ****************************************************************
module host_ctrl_model (
  input wire logic clk_sys, // System clock.
  input wire logic alert_out, // Alert drive value from the device.
  input wire logic alert_oe_n, // Alert enable, low pulls the pin.
  input wire logic [7:0] cfg_rdata, // Register read data.
  output logic refresh_plain, // Plain refresh command.
  output logic refresh_voltage, // Voltage-only refresh command.
  output logic refresh_general, // General-call refresh command.
  output logic cfg_wr_en, // Register write strobe.
  output logic [7:0] cfg_addr, // Register address.
  output logic [7:0] cfg_wdata, // Register write data.
  output logic alert_in // Resolved alert pin level.
);
  // The pin has a pull-up, so a released line reads high, never its last driven level.
  assign alert_in = alert_oe_n ? 1'b1 : alert_out;

  initial begin
    refresh_plain = 1'b0;
    refresh_voltage = 1'b0;
    refresh_general = 1'b0;
    cfg_wr_en = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end

  task automatic refresh(input int kind);
    @(negedge clk_sys);
    refresh_plain = (kind == 0);
    refresh_voltage = (kind == 1);
    refresh_general = (kind == 2);
    @(negedge clk_sys);
    refresh_plain = 1'b0;
    refresh_voltage = 1'b0;
    refresh_general = 1'b0;
  endtask : refresh

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    cfg_addr = a;
    @(negedge clk_sys);
    d = cfg_rdata;
  endtask : read_reg
endmodule : host_ctrl_model
`default_nettype wire

// >>> power_energy_accumulator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_energy_accumulator_tb;
  typedef struct packed {
    logic [63:0] vb, vs, ab, as;
    logic [191:0] acc;
    logic [23:0] cnt;
    logic es, ovf;
  } snap_t;
  logic clk_sys = 1'b0, reset = 1'b1, sample_valid = 1'b0, cycle_done = 1'b0;
  logic [1:0] sample_channel = 2'h0;
  logic signed [16:0] sample_bus_voltage = 17'h00000, sample_sense_voltage = 17'h00000;
  logic cycle_done_alert_enable = 1'b0, overflow_alert_enable = 1'b1;
  logic refresh_plain, refresh_voltage, refresh_general, cfg_wr_en, alert_in;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rd;
  logic [63:0] bus_voltage_result, sense_voltage_result, avg_bus_voltage_result;
  logic [63:0] avg_sense_voltage_result;
  logic [191:0] power_accumulator;
  logic [23:0] accumulator_count;
  logic energy_signed, overflow_flag, avg_valid, alert_out, alert_oe_n;
  logic [7:0] permute_setting;
  logic signed [16:0] hb[4][8], hs[4][8], lb[4], ls[4];
  logic signed [47:0] acc[4];
  logic [23:0] cnt = 24'h000000;
  int nsamp[4], n_mismatch = 0, total_checks = 0, cycles = 0;
  snap_t exp_q[$];
  snap_t held;

  always #20 clk_sys = ~clk_sys;

  power_energy_accumulator #(.CH_COUNT(4), .CH_IDX_W(2)) dut (
    .clk_sys(clk_sys), .reset(reset), .sample_valid(sample_valid),
    .sample_channel(sample_channel), .sample_bus_voltage(sample_bus_voltage),
    .sample_sense_voltage(sample_sense_voltage), .cycle_done(cycle_done),
    .refresh_plain(refresh_plain), .refresh_voltage(refresh_voltage),
    .refresh_general(refresh_general), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cycle_done_alert_enable(cycle_done_alert_enable),
    .overflow_alert_enable(overflow_alert_enable), .alert_in(alert_in),
    .cfg_rdata(cfg_rdata), .bus_voltage_result(bus_voltage_result),
    .sense_voltage_result(sense_voltage_result),
    .avg_bus_voltage_result(avg_bus_voltage_result),
    .avg_sense_voltage_result(avg_sense_voltage_result),
    .power_accumulator(power_accumulator), .accumulator_count(accumulator_count),
    .energy_signed(energy_signed), .overflow_flag(overflow_flag), .avg_valid(avg_valid),
    .permute_setting(permute_setting), .alert_out(alert_out), .alert_oe_n(alert_oe_n));

  host_ctrl_model host (
    .clk_sys(clk_sys), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .cfg_rdata(cfg_rdata), .refresh_plain(refresh_plain),
    .refresh_voltage(refresh_voltage), .refresh_general(refresh_general),
    .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .alert_in(alert_in));

  // ****************************************************************
  // Checking and expectation model
  // ****************************************************************
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  function automatic logic [15:0] fmt16(input logic [16:0] v, input logic sgn);
    return sgn ? v[16:1] : v[15:0];
  endfunction : fmt16

  function automatic snap_t model_snap(input logic [7:0] f);
    snap_t s;
    logic signed [19:0] sb, ss;
    logic bs, ssg;
    bs = f[power_energy_pkg::BUS_SIGNED_BIT];
    ssg = f[power_energy_pkg::SENSE_SIGNED_BIT];
    for (int ch = 0; ch < 4; ch++) begin
      sb = 20'h00000;
      ss = 20'h00000;
      for (int k = 0; k < 8; k++) begin
        sb = sb + hb[ch][k];
        ss = ss + hs[ch][k];
      end
      s.vb[ch*16+:16] = fmt16(lb[ch], bs);
      s.vs[ch*16+:16] = fmt16(ls[ch], ssg);
      s.ab[ch*16+:16] = fmt16(sb[19:3], bs);
      s.as[ch*16+:16] = fmt16(ss[19:3], ssg);
      s.acc[ch*48+:48] = acc[ch];
    end
    s.cnt = cnt;
    s.es = bs | ssg;
    s.ovf = 1'b0;
    return s;
  endfunction : model_snap

  // Snapshots are compared one edge after the command, when the registered copy has landed.
  always @(posedge clk_sys) begin
    if (refresh_plain | refresh_voltage | refresh_general) begin
      @(negedge clk_sys);
      if (exp_q.size() > 0) begin
        held = exp_q.pop_front();
        chk({bus_voltage_result, sense_voltage_result, avg_bus_voltage_result,
             avg_sense_voltage_result, power_accumulator, accumulator_count,
             energy_signed, overflow_flag} === held, "snapshot differs");
      end else begin
        chk(1'b0, "refresh without expectation");
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("[ERR] %0t run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task automatic conv_cycle();
    logic signed [16:0] b, s;
    logic signed [30:0] p;
    for (int ch = 0; ch < 4; ch++) begin
      b = 17'($urandom);
      s = 17'($urandom);
      @(negedge clk_sys);
      sample_valid = 1'b1;
      sample_channel = 2'(ch);
      sample_bus_voltage = b;
      sample_sense_voltage = s;
      hb[ch][nsamp[ch] % 8] = b;
      hs[ch][nsamp[ch] % 8] = s;
      lb[ch] = b;
      ls[ch] = s;
      p = s * $signed(b[16:3]);
      acc[ch] = acc[ch] + {{20{p[30]}}, p[30:3]};
      nsamp[ch]++;
    end
    @(negedge clk_sys);
    sample_valid = 1'b0;
    cycle_done = 1'b1;
    cnt++;
    @(negedge clk_sys);
    cycle_done = 1'b0;
    for (int ch = 0; ch < 4; ch++) begin
      chk(permute_setting[ch*2+:2] === 2'(nsamp[ch]), "permutation step");
    end
  endtask : conv_cycle

  initial begin
    for (int ch = 0; ch < 4; ch++) begin
      acc[ch] = 48'h000000000000;
      nsamp[ch] = 0;
      for (int k = 0; k < 8; k++) begin
        hb[ch][k] = 17'h00000;
        hs[ch][k] = 17'h00000;
      end
    end
    void'($urandom(86841));
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    chk({power_accumulator, accumulator_count, overflow_flag, avg_valid} === '0,
        "reset state");
    chk(alert_oe_n === 1'b1, "alert released");
    host.read_reg(8'h1d, rd);
    chk(rd === power_energy_pkg::SIGN_FORMAT_RESET, "format reset value");
    $display("test reset done");
    host.write_reg(8'h1d, 8'ha5);
    host.write_reg(8'h1e, 8'hff);
    host.read_reg(8'h1d, rd);
    chk(rd === 8'ha5, "format readback");
    host.read_reg(8'h1e, rd);
    chk(rd === 8'h00, "unmapped read");
    host.write_reg(8'h1d, 8'h00);
    $display("test register done");
    for (int c = 1; c <= 8; c++) begin
      conv_cycle();
      chk(avg_valid === (c == 8), "average settle");
      chk(alert_oe_n === 1'b1, "alert while disabled");
    end
    $display("test warmup done");
    for (int f = 0; f < 4; f++) begin
      host.write_reg(8'h1d, 8'(f));
      exp_q.push_back(model_snap(8'(f)));
      host.refresh(f % 3);
      conv_cycle();
      chk(bus_voltage_result === held.vb && power_accumulator === held.acc,
          "results moved without refresh");
    end
    $display("test refresh formats done");
    cycle_done_alert_enable = 1'b1;
    @(negedge clk_sys);
    cycle_done = 1'b1;
    cnt++;
    @(negedge clk_sys);
    cycle_done = 1'b0;
    @(negedge clk_sys);
    chk(alert_oe_n === 1'b0 && alert_in === 1'b0, "alert low");
    // Last low cycle and first released cycle are both probed, so the release edge is exact.
    repeat (123) @(negedge clk_sys);
    chk(alert_oe_n === 1'b0, "alert still low");
    @(negedge clk_sys);
    chk(alert_oe_n === 1'b1 && alert_in === 1'b1, "alert released");
    cycle_done_alert_enable = 1'b0;
    exp_q.push_back(model_snap(8'h03));
    host.refresh(2);
    $display("test alert done");
    repeat (2) @(negedge clk_sys);
    test_done();
  end
endmodule : power_energy_accumulator_tb
`default_nettype wire
